//--- common/sensor_cmd_pkg.sv
// Shared constants, types and decode helpers of the command decoder
package sensor_cmd_pkg;
   // Widths
   localparam int DATA_W = 24;
   localparam int SETUP_W = 16;
   localparam int ACC_W = 28;
   localparam int CNT_W = 5;
   localparam int SHIFT_W = 3;

   // Command codes
   localparam logic [7:0] CMD_RAW_BASE = 8'hA0;
   localparam logic [7:0] CMD_RAW_MASK = 8'hF8;
   localparam logic [7:0] CMD_OVS_BASE = 8'hAC;
   localparam logic [7:0] CMD_OVS_MASK = 8'hFC;
   localparam logic [7:0] CMD_OVS2 = 8'hAC;
   localparam logic [7:0] CMD_OVS4 = 8'hAD;
   localparam logic [7:0] CMD_OVS8 = 8'hAE;
   localparam logic [7:0] CMD_OVS16 = 8'hAF;
   localparam logic [7:0] CMD_SEL_PRI = 8'hB0;
   localparam logic [7:0] CMD_SEL_SEC = 8'hB1;
   localparam logic [7:0] CMD_HALT = 8'hBF;
   localparam logic [3:0] CMD_NOP_NIB = 4'hF;

   // Memory locations of the stored setups
   localparam logic [7:0] ADDR_SETUP_PRI = 8'h12;
   localparam logic [7:0] ADDR_SETUP_SEC = 8'h16;

   // Host setup word bits kept for temperature
   localparam logic [15:0] TEMP_SETUP_MASK = 16'h1FFF;

   // Status byte fields
   localparam logic STAT_TOP = 1'h0;
   localparam logic STAT_POWERED = 1'h1;
   localparam logic SEL_RESET = 1'h0;

   // Raw command field positions
   localparam int RAW_HOST_BIT = 0;
   localparam int RAW_AZ_BIT = 1;
   localparam int RAW_TEMP_BIT = 2;

   // Counter step
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

   // Decoder states
   typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_WAIT, ST_STORE} dec_state_e;

   // Raw measurement code
   function automatic logic is_raw(input logic [7:0] code);
      return (code & CMD_RAW_MASK) == CMD_RAW_BASE;
   endfunction

   // Oversampled measurement code
   function automatic logic is_ovs(input logic [7:0] code);
      return (code & CMD_OVS_MASK) == CMD_OVS_BASE;
   endfunction

   // No-operation code
   function automatic logic is_nop(input logic [7:0] code);
      return code[7:4] == CMD_NOP_NIB;
   endfunction
endpackage

//--- common/mean_if.sv
// Carrier between the decoder and its averaging accumulator
`timescale 1ns/1ns
interface mean_if;
   import sensor_cmd_pkg::*;
   logic clear;
   logic add;
   logic [DATA_W-1:0] sensor_in;
   logic [DATA_W-1:0] temp_in;
   logic [SHIFT_W-1:0] shift;
   logic [DATA_W-1:0] sensor_mean;
   logic [DATA_W-1:0] temp_mean;

   // Decoder drives the samples, reads the means
   modport ctrl (output clear, add, sensor_in, temp_in, shift,
                 input sensor_mean, temp_mean);
   // Accumulator side
   modport acc (input clear, add, sensor_in, temp_in, shift,
                output sensor_mean, temp_mean);
endinterface

//--- core/mean_accumulator.sv
// Two-channel sum and power-of-two mean for oversampling
`timescale 1ns/1ns
module mean_accumulator
   import sensor_cmd_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // Samples and means
   mean_if.acc m
);
   logic [ACC_W-1:0] sensor_sum_ff; // Sensor running sum
   logic [ACC_W-1:0] temp_sum_ff; // Temperature running sum
   logic [ACC_W-1:0] sensor_shr; // Shifted sensor sum
   logic [ACC_W-1:0] temp_shr; // Shifted temperature sum

   ////////////////////////////////////////////////////////////////////
   // Sensor sum
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || m.clear) begin
         sensor_sum_ff <= '0;
      end else if (m.add) begin
         sensor_sum_ff <= sensor_sum_ff + ACC_W'(m.sensor_in);
      end
   end

   // Temperature sum, kept apart from the sensor sum
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || m.clear) begin
         temp_sum_ff <= '0;
      end else if (m.add) begin
         temp_sum_ff <= temp_sum_ff + ACC_W'(m.temp_in);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Divide by the sample count, result stays 24 bits wide
   assign sensor_shr = sensor_sum_ff >> m.shift;
   assign temp_shr = temp_sum_ff >> m.shift;
   assign m.sensor_mean = sensor_shr[DATA_W-1:0];
   assign m.temp_mean = temp_shr[DATA_W-1:0];
endmodule // mean_accumulator

//--- core/setup_select.sv
// Chooses the front-end setup word for a measurement command
`timescale 1ns/1ns
module setup_select
   import sensor_cmd_pkg::*;
#(
   parameter logic [SETUP_W-1:0] FIXED_TEMP_SETUP = 16'h0000
)
(
   // Command
   input wire logic [7:0] i_code,
   input wire logic [SETUP_W-1:0] i_word,
   // Stored setups and selection
   input wire logic i_use_secondary,
   input wire logic [SETUP_W-1:0] i_primary,
   input wire logic [SETUP_W-1:0] i_secondary,
   // Result
   output logic [SETUP_W-1:0] o_setup
);
   logic [SETUP_W-1:0] stored; // Selected stored setup

   ////////////////////////////////////////////////////////////////////
   assign stored = i_use_secondary ? i_secondary : i_primary;

   // Host word for odd raw codes, else stored or fixed setup
   always_comb begin
      if (!is_raw(i_code)) begin
         o_setup = stored;
      end else if (i_code[RAW_HOST_BIT] && i_code[RAW_TEMP_BIT]) begin
         o_setup = i_word & TEMP_SETUP_MASK;
      end else if (i_code[RAW_HOST_BIT]) begin
         o_setup = i_word;
      end else if (i_code[RAW_TEMP_BIT]) begin
         o_setup = FIXED_TEMP_SETUP;
      end else begin
         o_setup = stored;
      end
   end
endmodule // setup_select

//--- core/sensor_measure_command_decoder.sv
// Measurement command decoder: oversampling, raw, setup select, halt, no-op
// Notes on behaviour
// - AC: two back-to-back corrected runs, mean
// - AD: four back-to-back corrected runs, mean
// - AE: eight back-to-back corrected runs, mean
// - AF: sixteen back-to-back corrected runs, mean
// - Oversampling uses stored setups, returns sensor+temperature
// - B0 selects primary setup, status bit1=0
// - B1 selects secondary setup, status bit1=1
// - BF powers down, halts, enters sleep
// - Fx no-op answers status and last data in SPI mode only
// - A0/A1 raw uncorrected sensor measurement
// - A2/A3 raw auto-zero corrected sensor measurement
// - A4/A5 raw temperature measurement
// - Odd raw codes load host setup word
// - Temperature host word ignores bits 15..13
// - Raw result stored as 24-bit word
// - Busy status bit blocks new commands except BF halt and Fx no-op
`timescale 1ns/1ns
module sensor_measure_command_decoder
   import sensor_cmd_pkg::*;
#(
   parameter logic [SETUP_W-1:0] FIXED_TEMP_SETUP = 16'h0000
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // Command from the serial framing
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_code,
   input wire logic [SETUP_W-1:0] i_cmd_data,
   input wire logic i_spi_mode,
   // Device context for the status byte
   input wire logic [1:0] i_mode,
   input wire logic i_mem_error,
   // Stored setups from nonvolatile settings memory
   input wire logic [SETUP_W-1:0] i_sensor_setup_primary,
   input wire logic [SETUP_W-1:0] i_sensor_setup_secondary,
   // Measurement path
   output logic o_meas_start,
   output logic o_meas_corrected,
   output logic o_meas_temperature,
   output logic o_meas_auto_zero,
   output logic [SETUP_W-1:0] o_afe_setup,
   input wire logic i_meas_done,
   input wire logic [DATA_W-1:0] i_meas_sensor,
   input wire logic [DATA_W-1:0] i_meas_temp,
   input wire logic i_meas_saturated,
   // Power control
   output logic o_sleep,
   output logic o_halt_periodic_operation,
   // Answer to the host
   output logic [7:0] o_status,
   output logic [DATA_W-1:0] o_result_sensor,
   output logic [DATA_W-1:0] o_result_temp,
   output logic o_reply_valid
);
   dec_state_e state_ff; // Sequencer state
   dec_state_e nxt_state; // Next sequencer state
   logic busy_ff; // Result not yet available
   logic sel_ff; // Secondary setup selected
   logic sat_ff; // Saturation seen in last measurement
   logic sleep_ff; // Measurement path powered down
   logic halt_ff; // One-cycle halt strobe
   logic reply_ff; // One-cycle no-op answer strobe
   logic start_ff; // One-cycle start strobe
   logic corr_ff; // Full corrected cycle
   logic temp_ff; // Raw temperature measurement
   logic az_ff; // Raw auto-zero measurement
   logic [SETUP_W-1:0] setup_ff; // Setup for the running command
   logic [1:0] mode_ff; // Registered device mode
   logic memerr_ff; // Registered memory error
   logic [CNT_W-1:0] total_ff; // Runs to perform
   logic [CNT_W-1:0] done_cnt_ff; // Runs completed
   logic [SHIFT_W-1:0] shift_ff; // Log2 of run count
   logic [DATA_W-1:0] res_sensor_ff; // Sensor or raw result
   logic [DATA_W-1:0] res_temp_ff; // Temperature result
   logic accept; // Command taken this cycle
   logic meas_cmd; // Taken command measures
   logic last_run; // Completing run is the final one
   logic [SETUP_W-1:0] setup_sel; // Setup chosen for this command
   logic [SHIFT_W-1:0] ovs_shift; // Shift for oversampling code
   mean_if mif ();
   ////////////////////////////////////////////////////////////////////
   // Decode helpers
   // busy blocks commands
   assign accept = i_cmd_valid && !busy_ff;
   assign meas_cmd = is_raw(i_cmd_code) || is_ovs(i_cmd_code);
   assign last_run = (done_cnt_ff + CNT_ONE) == total_ff;
   assign ovs_shift = SHIFT_W'(i_cmd_code[1:0]) + SHIFT_W'(1);
   // Setup word for the incoming command
   setup_select #(
      .FIXED_TEMP_SETUP(FIXED_TEMP_SETUP)
   ) u_setup (
      .i_code(i_cmd_code),
      .i_word(i_cmd_data),
      .i_use_secondary(sel_ff),
      .i_primary(i_sensor_setup_primary),
      .i_secondary(i_sensor_setup_secondary),
      .o_setup(setup_sel)
   );
   // Separate sensor and temperature averaging
   mean_accumulator u_mean (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .m(mif)
   );
   assign mif.clear = accept && meas_cmd;
   assign mif.add = (state_ff == ST_WAIT) && i_meas_done;
   assign mif.sensor_in = i_meas_sensor;
   assign mif.temp_in = i_meas_temp;
   assign mif.shift = shift_ff;
   ////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         // Wait for a measuring command
         ST_IDLE: begin
            if (accept && meas_cmd) begin
               nxt_state = ST_LAUNCH;
            end
         end
         // Start strobe stands one cycle
         ST_LAUNCH: nxt_state = ST_WAIT;
         ST_WAIT: begin
            if (i_meas_done) begin
               nxt_state = last_run ? ST_STORE : ST_LAUNCH;
            end
         end
         // Publish the mean
         ST_STORE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
      if (i_cmd_valid && i_cmd_code == CMD_HALT) begin
         nxt_state = ST_IDLE;
      end
   end
   // Sequencer state
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // Start strobe on each entry to launch
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         start_ff <= 1'b0;
      end else begin
         start_ff <= (nxt_state == ST_LAUNCH) && (state_ff != ST_LAUNCH);
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Command parameters captured on acceptance
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         corr_ff <= 1'b0;
         temp_ff <= 1'b0;
         az_ff <= 1'b0;
         setup_ff <= '0;
         total_ff <= CNT_ONE;
         shift_ff <= '0;
      end else if (accept && is_ovs(i_cmd_code)) begin
         corr_ff <= 1'b1;
         temp_ff <= 1'b0;
         az_ff <= 1'b0;
         setup_ff <= setup_sel;
         total_ff <= CNT_W'(CNT_ONE << ovs_shift);
         shift_ff <= ovs_shift;
      end else if (accept && is_raw(i_cmd_code)) begin
         corr_ff <= 1'b0;
         temp_ff <= i_cmd_code[RAW_TEMP_BIT];
         az_ff <= i_cmd_code[RAW_AZ_BIT];
         setup_ff <= setup_sel;
         total_ff <= CNT_ONE;
         shift_ff <= '0;
      end
   end
   // Runs completed so far
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || (accept && meas_cmd)) begin
         done_cnt_ff <= '0;
      end else if (state_ff == ST_WAIT && i_meas_done) begin
         done_cnt_ff <= done_cnt_ff + CNT_ONE;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Busy flag
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         busy_ff <= 1'b0;
      end else if (i_cmd_valid && i_cmd_code == CMD_HALT) begin
         busy_ff <= 1'b0;
      end else if (accept && meas_cmd) begin
         busy_ff <= 1'b1;
      end else if (state_ff == ST_STORE) begin
         busy_ff <= 1'b0;
      end
   end
   // Setup selection
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sel_ff <= SEL_RESET;
      end else if (accept && i_cmd_code == CMD_SEL_PRI) begin
         sel_ff <= 1'b0;
      end else if (accept && i_cmd_code == CMD_SEL_SEC) begin
         sel_ff <= 1'b1;
      end
   end
   // Saturation: gathered over runs, cleared by other commands
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sat_ff <= 1'b0;
      end else if (accept && !is_nop(i_cmd_code)) begin
         sat_ff <= 1'b0;
      end else if (state_ff == ST_WAIT && i_meas_done && i_meas_saturated) begin
         sat_ff <= 1'b1;
      end
   end
   // Sleep and halt strobe
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sleep_ff <= 1'b0;
         halt_ff <= 1'b0;
      end else begin
         halt_ff <= i_cmd_valid && i_cmd_code == CMD_HALT;
         if (i_cmd_valid && i_cmd_code == CMD_HALT) begin
            sleep_ff <= 1'b1;
         end else if (accept && meas_cmd) begin
            sleep_ff <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Results published at the end of the sequence
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         res_sensor_ff <= '0;
         res_temp_ff <= '0;
      end else if (state_ff == ST_STORE) begin
         res_sensor_ff <= mif.sensor_mean;
         if (corr_ff) begin
            res_temp_ff <= mif.temp_mean;
         end
      end
   end
   // No-op answer strobe, any time, SPI only
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         reply_ff <= 1'b0;
      end else begin
         reply_ff <= i_cmd_valid && is_nop(i_cmd_code) && i_spi_mode;
      end
   end
   // Device context sampled for the status byte
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         mode_ff <= '0;
         memerr_ff <= 1'b0;
      end else begin
         mode_ff <= i_mode;
         memerr_ff <= i_mem_error;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_meas_start = start_ff;
   assign o_meas_corrected = corr_ff;
   assign o_meas_temperature = temp_ff;
   assign o_meas_auto_zero = az_ff;
   assign o_afe_setup = setup_ff;
   assign o_sleep = sleep_ff;
   assign o_halt_periodic_operation = halt_ff;
   assign o_status = {STAT_TOP, STAT_POWERED, busy_ff, mode_ff, memerr_ff, sel_ff, sat_ff};
   assign o_result_sensor = res_sensor_ff;
   assign o_result_temp = res_temp_ff;
   assign o_reply_valid = reply_ff;
   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   sequence s_take(logic [7:0] c);
      i_cmd_valid && !busy_ff && i_cmd_code == c;
   endsequence
   sequence s_run_more;
      state_ff == ST_WAIT && i_meas_done && !last_run;
   endsequence
   chk_busy_on_take: assert property (accept && meas_cmd |=> busy_ff ##1 busy_ff)
      else $error("busy not raised on measurement");
   chk_busy_blocks: assert property (
      busy_ff && i_cmd_valid && i_cmd_code == CMD_SEL_SEC |=> $stable(o_status[1]))
      else $error("selection changed while busy");
   chk_sel_primary: assert property (s_take(CMD_SEL_PRI) |=> o_status[1] == 1'b0)
      else $error("primary select not shown");
   chk_sel_secondary: assert property (s_take(CMD_SEL_SEC) |=> o_status[1] == 1'b1)
      else $error("secondary select not shown");
   chk_halt_sleep: assert property (
      i_cmd_valid && i_cmd_code == CMD_HALT |=> o_sleep && !o_status[5] && o_halt_periodic_operation)
      else $error("halt did not sleep");
   chk_nop_answer: assert property (
      i_cmd_valid && is_nop(i_cmd_code) && i_spi_mode |=> o_reply_valid && o_status[6])
      else $error("no-op not answered");
   chk_no_pause: assert property (s_run_more |=> o_meas_start)
      else $error("pause between runs");
   chk_ovs16_count: assert property (s_take(CMD_OVS16) |=> total_ff == 5'h10)
      else $error("sixteen runs not set");
   chk_ovs2_count: assert property (s_take(CMD_OVS2) |=> total_ff == 5'h02 && o_meas_corrected)
      else $error("two runs not set");
   chk_temp_mask: assert property (
      accept && i_cmd_code == 8'hA5 |=> o_afe_setup == ($past(i_cmd_data) & TEMP_SETUP_MASK))
      else $error("temperature setup bits kept");
   chk_store_count: assert property (state_ff == ST_STORE |-> done_cnt_ff == total_ff)
      else $error("stored before all runs");
endmodule // sensor_measure_command_decoder

//--- testbench/meas_path_model.sv
// Behavioural measurement path that answers the decoder's run requests
`timescale 1ns/1ns
module meas_path_model (
   // Clock and restart
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // Run control
   input wire logic i_start,
   input wire logic [7:0] i_delay,
   input wire logic [23:0] i_base,
   input wire logic i_sat,
   // Run results
   output logic o_done,
   output logic [23:0] o_sensor,
   output logic [23:0] o_temp,
   output logic o_saturated
);
   logic busy_ff; // A run is in flight
   logic [7:0] wait_ff; // Cycles left in the run
   logic [7:0] run_ff; // Runs since restart
   logic [23:0] step; // Offset of this run

   assign step = {15'h0000, run_ff, 1'h0};

   ////////////////////////////////////////
   // One run at a time; results hold only with done, else they toggle
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         busy_ff <= 1'h0;
         wait_ff <= 8'h00;
         run_ff <= 8'h00;
         o_done <= 1'h0;
         o_sensor <= 24'h5A5A5A;
         o_temp <= 24'hA5A5A5;
         o_saturated <= 1'h0;
      end else if (busy_ff && !i_start && wait_ff == 8'h00) begin
         // Run complete: results stand with done for one cycle
         o_done <= 1'h1;
         busy_ff <= 1'h0;
         run_ff <= run_ff + 8'h01;
         o_sensor <= i_base + step;
         o_temp <= i_base + 24'h100000 + step;
         o_saturated <= i_sat;
      end else begin
         // Between results the words show junk
         o_done <= 1'h0;
         o_sensor <= ~o_sensor;
         o_temp <= ~o_temp;
         o_saturated <= ~o_saturated;
         if (i_start) begin
            busy_ff <= 1'h1;
            wait_ff <= i_delay;
         end else if (busy_ff) begin
            wait_ff <= wait_ff - 8'h01;
         end
      end
   end
endmodule // meas_path_model

//--- testbench/tb_top.sv
// Self-checking bench of the measurement command decoder
`timescale 1ns/1ns
module tb_top;
   import sensor_cmd_pkg::*;
   localparam logic [15:0] FIX = 16'h0ABC; // Arbitrary fixed temp setup
   localparam logic [15:0] PRI = 16'h1234; // Primary stored setup
   localparam logic [15:0] SEC = 16'hC5A7; // Secondary stored setup
   logic i_clock, i_sys_rst, valid, spi, merr, clr, sat, sel;
   logic [7:0] code, dly, status;
   logic [15:0] data, afe, xafe;
   logic [1:0] mode;
   logic [23:0] base, ms, mt, rs, rt, xs, xt;
   logic start, corr, temp, az, done, msat, sleep, halt, reply;
   int miscompares, cmp_count, starts, cycles, n;

   sensor_measure_command_decoder #(.FIXED_TEMP_SETUP(FIX)) u_dut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cmd_valid(valid),
      .i_cmd_code(code), .i_cmd_data(data), .i_spi_mode(spi), .i_mode(mode),
      .i_mem_error(merr), .i_sensor_setup_primary(PRI),
      .i_sensor_setup_secondary(SEC), .o_meas_start(start),
      .o_meas_corrected(corr), .o_meas_temperature(temp),
      .o_meas_auto_zero(az), .o_afe_setup(afe), .i_meas_done(done),
      .i_meas_sensor(ms), .i_meas_temp(mt), .i_meas_saturated(msat),
      .o_sleep(sleep), .o_halt_periodic_operation(halt), .o_status(status),
      .o_result_sensor(rs), .o_result_temp(rt), .o_reply_valid(reply));

   meas_path_model u_path (
      .i_clock(i_clock), .i_sys_rst(clr), .i_start(start), .i_delay(dly),
      .i_base(base), .i_sat(sat), .o_done(done), .o_sensor(ms),
      .o_temp(mt), .o_saturated(msat));

   ////////////////////////////////////////
   // Clock, run counter, timeout
   initial begin
      i_clock = 1'h0;
      forever #4 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (start === 1'h1) starts++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   ////////////////////////////////////////
   // Compare and report
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // code and word go as one request
   task automatic cmd(input logic [7:0] c, input logic [15:0] d);
      @(posedge i_clock);
      #1 valid = 1'h1;
      code = c;
      data = d;
      @(posedge i_clock);
      #1 valid = 1'h0;
   endtask
   // Restart the path model with latency, base value and saturation
   task automatic restart(input logic [7:0] d, input logic [23:0] b, input logic s);
      clr = 1'h1;
      dly = d;
      base = b;
      sat = s;
      starts = 0;
      @(posedge i_clock);
      #1 clr = 1'h0;
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 3000 && status[5] !== 1'h0; k++) begin
         @(posedge i_clock);
         #1;
      end
      // A run that never ends counts as a mismatch
      chk(status[5], 1'h0);
   endtask
   task automatic end_of_test();
      $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////
   initial begin
      {i_sys_rst, clr, spi} = 3'h7;
      {valid, merr, sat, sel} = 4'h0;
      {code, dly, data, mode, base} = 58'h0;
      {miscompares, cmp_count, starts, cycles} = 128'h0;
      repeat (10) @(posedge i_clock);
      #1 i_sys_rst = 1'h0;
      clr = 1'h0;
      chk(status, 8'h40);
      mode = 2'h1;
      merr = 1'h1;
      repeat (2) @(posedge i_clock);
      #1 chk(status, 8'h4C);
      {mode, merr} = 3'h0;
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         n = 2 << i;
         restart(8'(3 * i), 24'h111111 * 24'(i + 1), 1'h0);
         cmd(CMD_OVS2 + 8'(i), 16'h0000);
         chk(afe, PRI);
         chk(corr, 1'h1);
         wait_idle();
         chk(24'(starts), 24'(n));
         xs = base + 24'(n - 1);
         xt = xs + 24'h100000;
         chk(rs, xs);
         chk(rt, xt);
      end
      $display("test oversample done");
      for (int c = 0; c < 8; c++) begin
         sel = c[1];
         cmd(sel ? CMD_SEL_SEC : CMD_SEL_PRI, 16'h0000);
         chk(status[1], sel);
         restart(8'h00, 24'h00A000 + 24'(c), c[0]);
         cmd(CMD_RAW_BASE + 8'(c), c[0] ? 16'hFFFF : 16'h0000);
         xafe = c[2] ? FIX : (sel ? SEC : PRI);
         if (c[0]) xafe = c[2] ? 16'h1FFF : 16'hFFFF;
         chk(afe, xafe);
         chk({temp, az, corr}, {c[2], c[1], 1'h0});
         wait_idle();
         xs = base;
         chk(rs, xs);
         chk(rt, xt);
         chk(status[1:0], {sel, c[0]});
      end
      $display("test raw done");
      cmd(CMD_SEL_PRI, 16'h0000);
      restart(8'h32, 24'h777777, 1'h0);
      cmd(CMD_OVS4, 16'h0000);
      cmd(CMD_SEL_SEC, 16'h0000);
      chk(status[5:1], 5'h10);
      cmd(8'hF3, 16'h0000);
      chk(reply, 1'h1);
      // no-op is not a valid request outside SPI
      spi = 1'h0;
      cmd(8'hF0, 16'h0000);
      chk(reply, 1'h0);
      spi = 1'h1;
      cmd(CMD_HALT, 16'h0000);
      chk({sleep, halt, status[5]}, 3'h6);
      repeat (80) @(posedge i_clock);
      #1 chk(rs, xs);
      chk(rt, xt);
      $display("test busy and halt done");
      cmd(CMD_SEL_SEC, 16'h0000);
      chk(status[1], 1'h1);
      i_sys_rst = 1'h1;
      @(posedge i_clock);
      #1 i_sys_rst = 1'h0;
      chk(status, 8'h40);
      $display("test reset restore done");
      end_of_test();
   end
endmodule // tb_top
